// >>> bench/hbm_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  num_errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module hbm_ctrl_tb;
  import hbm_pkg::*;
  logic     MCLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, VCC_EN;
  logic     MODE_OUT, MODE_OE, CTRL_IN_A, CTRL_IN_B, dev_a, dev_b, dev_awake;
  addr_type AVS_ADDRESS;
  data_type AVS_WRITEDATA, AVS_READDATA, v;
  pins_type pin_now;
  assign pin_now = {VCC_EN, MODE_OUT, MODE_OE, CTRL_IN_A, CTRL_IN_B};
  int       num_errors = 0;
  int       n_tests    = 0;
  hbm_ctrl #(.SLEEP_TIME_US(3), .WAKE_TIME_US(2), .POWER_TIME_US(1)) i_dut (
    .MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .VCC_EN(VCC_EN),
    .MODE_OUT(MODE_OUT), .MODE_OE(MODE_OE), .CTRL_IN_A(CTRL_IN_A),
    .CTRL_IN_B(CTRL_IN_B));
  hbm_dev_model i_dev (
    .clk(MCLK), .vcc(VCC_EN), .mode_o(MODE_OUT), .mode_oe(MODE_OE),
    .in_a(CTRL_IN_A), .in_b(CTRL_IN_B), .out_a(dev_a), .out_b(dev_b),
    .awake(dev_awake));
  initial begin
    MCLK = 1'h0;
    forever #10 MCLK = ~MCLK;
  end
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  // Extra edge at the end keeps two requests from sharing a time step
  task automatic bus(input logic wr, input addr_type ad, input data_type wd,
                     output data_type rd);
    int k;
    AVS_ADDRESS   <= ad;
    AVS_WRITEDATA <= wd;
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (AVS_WAITREQUEST !== 1'h0 && k < 20);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'h0;
    AVS_READ  <= 1'h0;
    if (k >= 20) begin
      num_errors++;
      close_out();
    end
    @(posedge MCLK);
  endtask : bus
  task automatic wr(input addr_type ad, input data_type d);
    data_type x;
    bus(1'h1, ad, d, x);
  endtask : wr
  task automatic wait_st(input data_type ex);
    int k;
    k = 0;
    do begin
      bus(1'h0, REG_STATUS, 32'h0, v);
      k++;
    end while (v !== ex && k < 300);
    `CHK("status", ex, v)
    if (v !== ex) begin
      close_out();
    end
  endtask : wait_st
  task automatic pins(input logic ea, input logic eb, input logic ew);
    repeat (4) @(posedge MCLK);
    `CHK("out_a", ea, dev_a)
    `CHK("out_b", eb, dev_b)
    `CHK("awake", ew, dev_awake)
  endtask : pins
  task automatic t_reset;
    `CHK("pins", PINS_RESET, pin_now)
    bus(1'h0, REG_DUTY, 32'h0, v);
    `CHK("duty", 32'h80, v)
    wr(REG_DUTY, 32'h1ff);
    bus(1'h0, REG_DUTY, 32'h0, v);
    `CHK("duty", 32'hff, v)
    wr(REG_STATUS, 32'h3f);
    wr(2'h3, 32'h7);
    bus(1'h0, 2'h3, 32'h0, v);
    `CHK("unmapped", 32'h0, v)
    bus(1'h0, REG_CTRL, 32'h0, v);
    `CHK("ctrl", 32'h0, v)
    wait_st(32'h81);
  endtask : t_reset
  task automatic t_pwm;
    wr(REG_CTRL, 32'h64);
    wait_st(32'hd0);
    pins(1'h1, 1'h0, 1'h1);
    wr(REG_CTRL, 32'h24);
    pins(1'h1, 1'h0, 1'h1);
    wr(REG_CTRL, 32'h54);
    pins(1'h0, 1'h1, 1'h1);
    wr(REG_CTRL, 32'h74);
    pins(1'h0, 1'h0, 1'h1);
    wr(REG_CTRL, 32'h44);
    pins(1'hz, 1'hz, 1'h1);
    wait_st(32'h81);
    pins(1'hz, 1'hz, 1'h0);
    wr(REG_CTRL, 32'h0);
    `CHK("ins", 2'h0, {CTRL_IN_A, CTRL_IN_B})
  endtask : t_pwm
  task automatic t_phen;
    wr(REG_CTRL, 32'h09);
    wait_st(32'h02);
    pins(1'hz, 1'hz, 1'h0);
    wr(REG_CTRL, 32'h65);
    wait_st(32'hd0);
    `CHK("mode", MPIN_HIGH, {MODE_OUT, MODE_OE})
    pins(1'h1, 1'h0, 1'h1);
    wr(REG_CTRL, 32'h55);
    pins(1'h0, 1'h1, 1'h1);
    wr(REG_CTRL, 32'h09);
    pins(1'h0, 1'h0, 1'h1);
    wait_st(32'h02);
    pins(1'hz, 1'hz, 1'h0);
  endtask : t_phen
  task automatic t_half;
    wr(REG_CTRL, 32'h66);
    wait_st(32'hd0);
    `CHK("mode_oe", 1'h0, MODE_OE)
    pins(1'h1, 1'h0, 1'h1);
    wr(REG_CTRL, 32'h56);
    pins(1'h0, 1'h1, 1'h1);
  endtask : t_half
  initial begin
    RST_N         = 1'h0;
    AVS_ADDRESS   = 2'h0;
    AVS_READ      = 1'h0;
    AVS_WRITE     = 1'h0;
    AVS_WRITEDATA = 32'h0;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'h1;
    @(posedge MCLK);
    t_reset();
    t_pwm();
    t_phen();
    t_half();
    close_out();
  end
endmodule : hbm_ctrl_tb
`default_nettype wire

// >>> bench/hbm_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbm_dev_model #(
  parameter int WAKE_CYC  = 90,
  parameter int SLEEP_CYC = 140
) (
  input  wire logic clk,
  input  wire logic vcc,
  input  wire logic mode_o,
  input  wire logic mode_oe,
  input  wire logic in_a,
  input  wire logic in_b,
  output logic      out_a,
  output logic      out_b,
  output logic      awake
);
  logic [1:0] mode = 2'h0;
  logic       pup  = 1'h0;
  logic       rest;
  logic       hold;
  int         cnt  = 0;
  initial awake = 1'h0;
  // Interface latched once per power-up, as wake begins
  assign rest = (mode == 2'h1) ? !in_b : !in_a && !in_b
                && (mode == 2'h0 || (mode_oe && !mode_o));
  assign hold = (mode == 2'h1) ? in_b : in_a || in_b;
  always @(posedge clk) begin
    if (vcc !== 1'h1) begin
      awake <= 1'h0;
      pup   <= 1'h1;
      cnt   <= 0;
    end else if (awake) begin
      cnt <= rest ? cnt + 1 : 0;
      if (rest && cnt >= SLEEP_CYC) begin
        awake <= 1'h0;
        cnt   <= 0;
      end
    end else begin
      cnt <= hold ? cnt + 1 : 0;
      if (pup && hold) begin
        mode <= mode_oe ? {1'h0, mode_o} : 2'h2;
        pup  <= 1'h0;
      end
      if (hold && cnt >= WAKE_CYC) begin
        awake <= 1'h1;
        cnt   <= 0;
      end
    end
  end
  always_comb begin
    out_a = 1'hz;
    out_b = 1'hz;
    if (awake && mode == 2'h1) begin
      out_a = in_b && in_a;
      out_b = in_b && !in_a;
    end else if (awake && !rest && mode == 2'h2) begin
      out_a = in_a;
      out_b = in_b;
    end else if (awake && !rest) begin
      out_a = in_a && !in_b;
      out_b = in_b && !in_a;
    end
  end
endmodule : hbm_dev_model
`default_nettype wire

// >>> core/hbm_ctrl.sv
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module hbm_ctrl #(
  parameter int SLEEP_TIME_US = hbm_pkg::SLEEP_TIME_US_DEF,
  parameter int WAKE_TIME_US  = hbm_pkg::WAKE_TIME_US_DEF,
  parameter int POWER_TIME_US = hbm_pkg::POWER_TIME_US_DEF
) (
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  input  wire hbm_pkg::addr_type AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire hbm_pkg::data_type AVS_WRITEDATA,
  output hbm_pkg::data_type      AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  output logic                   VCC_EN,
  output logic                   MODE_OUT,
  output logic                   MODE_OE,
  output logic                   CTRL_IN_A,
  output logic                   CTRL_IN_B
);
  import hbm_pkg::*;

  // Rounds up so a timed wait never comes out shorter than asked
  function automatic int us_ticks(int us);
    us_ticks = (us * NS_PER_US + TICK_NS - 1) / TICK_NS;
  endfunction : us_ticks

  // A spare tick covers the partial first one, so no wait runs short
  localparam int WAKE_TICKS  = us_ticks(WAKE_TIME_US) + 1;
  localparam int SLEEP_TICKS = us_ticks(SLEEP_TIME_US) + 1;
  localparam int POWER_TICKS = us_ticks(POWER_TIME_US) + 1;
  localparam cnt_type WAKE_LAST  = cnt_type'(WAKE_TICKS - 1);
  localparam cnt_type SLEEP_LAST = cnt_type'(SLEEP_TICKS - 1);
  localparam cnt_type POWER_LAST = cnt_type'(POWER_TICKS - 1);

  ctrl_type   ctrl;
  ctrl_type   next_ctrl;
  duty_type   duty;
  duty_type   next_duty;
  data_type   rdata;
  data_type   next_rdata;
  logic       wait_req;
  logic       next_wait_req;
  state_type  st;
  state_type  next_st;
  cnt_type    cnt;
  cnt_type    next_cnt;
  pins_type   pins;
  pins_type   next_pins;
  status_type status;
  logic       tick;
  logic       pwm_on;
  logic       lvl;
  logic       fwd_sel;

  function automatic logic [1:0] mode_drive(iface_type f, logic hold_low);
    case (f)
      IF_PHEN: mode_drive = MPIN_HIGH;
      IF_HALF: mode_drive = hold_low ? MPIN_LOW : MPIN_FLOAT;
      default: mode_drive = MPIN_LOW;
    endcase
  endfunction : mode_drive

  // True when the pins form a state in which the device counts to sleep
  function automatic logic is_entry(pins_type p);
    is_entry = p.mode_oe && !p.b && (p.mode_o || !p.a);
  endfunction : is_entry

  function automatic logic [1:0] drive_ab(iface_type f, drive_type d,
                                          logic l);
    case (f)
      IF_PHEN: drive_ab = {d == DRV_FWD,
                           (d == DRV_FWD || d == DRV_REV) && l};
      IF_HALF: drive_ab = {d[1] && l, d[0] && l};
      default: drive_ab = {(d == DRV_FWD && l) || d == DRV_BRAKE,
                           (d == DRV_REV && l) || d == DRV_BRAKE};
    endcase
  endfunction : drive_ab

  // Drive request that would leave the pins in a sleep-entry state
  function automatic logic drive_rests(iface_type f, drive_type d);
    pins_type p;
    p = PINS_RESET;
    {p.mode_o, p.mode_oe} = mode_drive(f, 1'b0);
    {p.a, p.b} = drive_ab(f, d, 1'b1);
    drive_rests = is_entry(p);
  endfunction : drive_rests

  hbm_pwm #(
    .DIV    (TICK_DIV),
    .DUTY_W (DUTY_W)
  ) u_pwm (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .duty   (duty),
    .tick   (tick),
    .pwm_on (pwm_on)
  );

  assign lvl     = ctrl.pwm_en ? pwm_on : 1'b1;
  assign fwd_sel = (ctrl.drive == DRV_FWD);
  // Only run and idle mean the device is known to be awake
  assign status  = {pins.vcc, (st == ST_RUN) || (st == ST_IDLE), st};

  always_comb begin
    next_ctrl     = ctrl;
    next_duty     = duty;
    next_rdata    = rdata;
    next_wait_req = 1'b1;
    if ((AVS_READ || AVS_WRITE) && wait_req) begin
      next_wait_req = 1'b0;
      case (AVS_ADDRESS)
        REG_CTRL:   next_rdata = data_type'(ctrl);
        REG_DUTY:   next_rdata = data_type'(duty);
        REG_STATUS: next_rdata = data_type'(status);
        default:    next_rdata = '0;
      endcase
    end
    if (AVS_WRITE && !wait_req) begin
      case (AVS_ADDRESS)
        REG_CTRL: next_ctrl = ctrl_type'(AVS_WRITEDATA[CTRL_W-1:0]);
        REG_DUTY: next_duty = AVS_WRITEDATA[DUTY_W-1:0];
        default:  next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl     <= CTRL_RESET;
      duty     <= DUTY_RESET;
      rdata    <= '0;
      wait_req <= 1'b1;
    end else begin
      ctrl     <= next_ctrl;
      duty     <= next_duty;
      rdata    <= next_rdata;
      wait_req <= next_wait_req;
    end
  end

  always_comb begin
    next_st   = st;
    next_cnt  = tick ? cnt + 1'b1 : cnt;
    next_pins = PINS_RESET;
    {next_pins.mode_o, next_pins.mode_oe} = mode_drive(ctrl.iface, 1'b0);
    case (st)
      ST_SLEEP: begin
        // Half-bridge only sleeps with the mode pin pulled low
        {next_pins.mode_o, next_pins.mode_oe} = mode_drive(ctrl.iface, 1'b1);
        next_cnt = '0;
        // A resting drive would only fall asleep again, so it does not wake
        if (ctrl.run && !drive_rests(ctrl.iface, ctrl.drive)) begin
          next_st = ST_WAKE;
        end else if (ctrl.supply_sleep) begin
          next_st = ST_OFF;
        end
      end
      ST_OFF: begin
        next_pins.vcc = 1'b0;
        {next_pins.mode_o, next_pins.mode_oe} = MPIN_LOW;
        next_cnt = '0;
        if (ctrl.run && !drive_rests(ctrl.iface, ctrl.drive)) begin
          next_st = ST_POWER;
        end
      end
      ST_POWER: begin
        if (tick && cnt >= POWER_LAST) begin
          next_st  = ST_WAKE;
          next_cnt = '0;
        end
      end
      ST_WAKE: begin
        next_pins.a = (ctrl.iface == IF_PHEN) ? fwd_sel : 1'b1;
        next_pins.b = 1'b1;
        if (!ctrl.run) begin
          next_st  = ST_IDLE;
          next_cnt = '0;
        end else if (tick && cnt >= WAKE_LAST) begin
          next_st  = ST_RUN;
          next_cnt = '0;
        end
      end
      ST_RUN: begin
        // Re-driven each cycle so a recovered bridge follows the command
        {next_pins.a, next_pins.b} =
          drive_ab(ctrl.iface, ctrl.drive, lvl);
        if (!ctrl.run) begin
          next_st  = ST_IDLE;
          next_cnt = '0;
        end else if (!is_entry(next_pins)) begin
          next_cnt = '0;
        end else if (tick && cnt >= SLEEP_LAST) begin
          next_st  = ST_SLEEP;
          next_cnt = '0;
        end
      end
      ST_IDLE: begin
        {next_pins.mode_o, next_pins.mode_oe} = mode_drive(ctrl.iface, 1'b1);
        if (ctrl.run) begin
          next_st  = ST_RUN;
          next_cnt = '0;
        end else if (tick && cnt >= SLEEP_LAST) begin
          next_st  = ctrl.supply_sleep ? ST_OFF : ST_SLEEP;
          next_cnt = '0;
        end
      end
      default: begin
        next_st  = ST_SLEEP;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st   <= ST_SLEEP;
      cnt  <= '0;
      pins <= PINS_RESET;
    end else begin
      st   <= next_st;
      cnt  <= next_cnt;
      pins <= next_pins;
    end
  end

  assign AVS_READDATA    = rdata;
  assign AVS_WAITREQUEST = wait_req;
  assign VCC_EN          = pins.vcc;
  assign MODE_OUT        = pins.mode_o;
  assign MODE_OE         = pins.mode_oe;
  assign CTRL_IN_A       = pins.a;
  assign CTRL_IN_B       = pins.b;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_power_end;
    st == ST_POWER ##1 st == ST_WAKE;
  endsequence

  sequence s_wake_end;
    st == ST_WAKE ##1 st == ST_RUN;
  endsequence

  a_wake_high: assert property ($past(st) == ST_WAKE |-> CTRL_IN_B)
    else $error("wake input not held high");
  a_wake_length: assert property (
    s_wake_end |-> $past(cnt) == WAKE_LAST)
    else $error("run entered before wake interval");
  a_sleep_low: assert property (
    ($past(st) == ST_SLEEP || $past(st) == ST_OFF)
      |-> !CTRL_IN_A && !CTRL_IN_B)
    else $error("inputs not low in sleep");
  a_off_supply: assert property ($past(st) == ST_OFF |-> !VCC_EN)
    else $error("supply on in supply sleep");
  a_power_wake: assert property (
    s_power_end |-> $past(cnt) == POWER_LAST && VCC_EN)
    else $error("wake began before supply settled");
  a_entry_restart: assert property (
    st == ST_RUN && !is_entry(next_pins) |=> cnt == '0)
    else $error("sleep count not restarted");
  a_pwm_fwd: assert property (
    st == ST_RUN && ctrl.run && ctrl.iface == IF_PWM && fwd_sel
      && !ctrl.pwm_en |=> CTRL_IN_A && !CTRL_IN_B)
    else $error("forward decode wrong");
  a_phen_dir: assert property (
    st == ST_RUN && ctrl.run && ctrl.iface == IF_PHEN
      |=> CTRL_IN_A == $past(fwd_sel))
    else $error("direction pin wrong");
  a_idle_sleep: assert property (
    st == ST_IDLE && !ctrl.run && tick && cnt >= SLEEP_LAST
      |=> st == ST_SLEEP || st == ST_OFF)
    else $error("idle did not reach sleep");
  a_run_autosleep: assert property (
    st == ST_RUN && ctrl.run && is_entry(next_pins) && tick
      && cnt >= SLEEP_LAST |=> st == ST_SLEEP)
    else $error("autosleep not tracked");
  a_idle_return: assert property (
    st == ST_IDLE && ctrl.run |=> st == ST_RUN)
    else $error("idle did not return to run");
  a_bus_answer: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered");
endmodule : hbm_ctrl
`default_nettype wire

// >>> core/hbm_pkg.sv
`default_nettype none
package hbm_pkg;
  localparam int CLK_PERIOD_NS     = 20;
  localparam int TICK_NS           = 1000;
  localparam int NS_PER_US         = 1000;
  localparam int TICK_DIV          = TICK_NS / CLK_PERIOD_NS;
  localparam int DUTY_W            = 8;
  localparam int CNT_W             = 16;
  localparam int CTRL_W            = 7;
  localparam int WAKE_TIME_US_DEF  = 1000;
  localparam int SLEEP_TIME_US_DEF = 2000;
  localparam int POWER_TIME_US_DEF = 100;

  typedef logic [1:0]        addr_type;
  typedef logic [31:0]       data_type;
  typedef logic [CNT_W-1:0]  cnt_type;
  typedef logic [DUTY_W-1:0] duty_type;

  localparam addr_type REG_CTRL   = 2'h0;
  localparam addr_type REG_DUTY   = 2'h1;
  localparam addr_type REG_STATUS = 2'h2;

  typedef enum logic [1:0] {
    IF_PWM  = 2'h0,
    IF_PHEN = 2'h1,
    IF_HALF = 2'h2
  } iface_type;

  typedef enum logic [1:0] {
    DRV_COAST = 2'h0,
    DRV_REV   = 2'h1,
    DRV_FWD   = 2'h2,
    DRV_BRAKE = 2'h3
  } drive_type;

  typedef struct packed {
    logic      pwm_en;
    drive_type drive;
    logic      supply_sleep;
    logic      run;
    iface_type iface;
  } ctrl_type;

  typedef struct packed {
    logic vcc;
    logic mode_o;
    logic mode_oe;
    logic a;
    logic b;
  } pins_type;

  typedef enum logic [5:0] {
    ST_SLEEP = 6'h01,
    ST_OFF   = 6'h02,
    ST_POWER = 6'h04,
    ST_WAKE  = 6'h08,
    ST_RUN   = 6'h10,
    ST_IDLE  = 6'h20
  } state_type;

  typedef struct packed {
    logic      vcc;
    logic      awake;
    state_type state;
  } status_type;

  // Mode pin encodings as {level, enable}
  localparam logic [1:0] MPIN_LOW   = 2'h1;
  localparam logic [1:0] MPIN_HIGH  = 2'h3;
  localparam logic [1:0] MPIN_FLOAT = 2'h0;

  localparam ctrl_type CTRL_RESET = 7'h00;
  localparam duty_type DUTY_RESET = 8'h80;
  localparam pins_type PINS_RESET = 5'h14;
endpackage : hbm_pkg
`default_nettype wire

// >>> core/hbm_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module hbm_pwm #(
  parameter int DIV    = hbm_pkg::TICK_DIV,
  parameter int DUTY_W = hbm_pkg::DUTY_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [DUTY_W-1:0] duty,
  output logic                   tick,
  output logic                   pwm_on
);
  localparam int DW = $clog2(DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

  logic [DW-1:0]     div;
  logic [DW-1:0]     next_div;
  logic [DUTY_W-1:0] ph;
  logic [DUTY_W-1:0] next_ph;
  logic              next_tick;
  logic              next_pwm_on;

  always_comb begin
    next_div    = (div == DIV_LAST) ? '0 : div + 1'b1;
    next_tick   = (div == DIV_LAST);
    next_ph     = ph + 1'b1;
    // All ones means fully on, since ph < duty alone would leave one phase per period low
    next_pwm_on = (duty == '1) || (ph < duty);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div    <= '0;
      ph     <= '0;
      tick   <= 1'b0;
      pwm_on <= 1'b0;
    end else begin
      div    <= next_div;
      ph     <= next_ph;
      tick   <= next_tick;
      pwm_on <= next_pwm_on;
    end
  end
endmodule : hbm_pwm
`default_nettype wire
